//--- src/mq_core.sv
// Multi-queue flow-control core, device end of the link
`timescale 1ns/100ps
`include "mq_map.svh"
module mq_core
	import mq_pkg::*;
(
	input  wire logic   clk_in,
	input  wire logic   rst_in,
	input  wire logic   high_density_in,
	input  wire logic [7:0] num_queues_in,
	input  wire logic   wide_in_in,
	input  wire logic   wide_out_in,
	input  wire logic   back_off_one_mode_in,
	input  wire logic   thr_load_in,
	input  wire qsel_t  thr_queue_in,
	input  wire level_t af_thr_in,
	input  wire level_t ae_thr_in,
	mq_if.device        link
);
	////////////////////////////////////////////////////////////////
	// Configuration caught at reset
	logic [7:0]  nq_q;
	logic [10:0] blocks_q;
	logic        wide_in_q;
	logic        wide_out_q;
	logic        backoff_q;
	level_t      wpq_q;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			nq_q       <= (num_queues_in == 8'h00) ? 8'h01 :
			              (num_queues_in > 8'h80) ? 8'h80 : num_queues_in;
			blocks_q   <= high_density_in ? 11'(`MQ_BLOCKS_HIGH) : 11'(`MQ_BLOCKS_LOW);
			wide_in_q  <= wide_in_in;
			wide_out_q <= wide_out_in;
			backoff_q  <= back_off_one_mode_in;
		end
	end

	// Words per queue, a whole number of blocks
	always_ff @(posedge clk_in) begin
		wpq_q <= `MQ_LEVEL_BITS'((blocks_q / 11'(nq_q)) * 11'(`MQ_BLOCK_WORDS / 256) *
		         `MQ_LEVEL_BITS'(`MQ_BLOCK_WORDS));
	end

	function automatic logic active(input qsel_t q, input logic [7:0] n);
		active = ({1'b0, q} < n);
	endfunction

	function automatic addr_t word_addr(input qsel_t q, input level_t wpq, input addr_t off);
		logic [26:0] base;
		base      = 27'(q) * 27'(wpq);
		word_addr = addr_t'(base) + off;
	endfunction

	////////////////////////////////////////////////////////////////
	// Per-queue state
	level_t level_q [0:`MQ_NUM_QUEUES-1];
	addr_t  wptr_q  [0:`MQ_NUM_QUEUES-1];
	addr_t  rptr_q  [0:`MQ_NUM_QUEUES-1];
	level_t af_q    [0:`MQ_NUM_QUEUES-1];
	level_t ae_q    [0:`MQ_NUM_QUEUES-1];

	qsel_t  wq;
	qsel_t  rq;
	logic   push;
	logic   pop;
	word_t  push_word;

	assign wq = link.write_queue_select;
	assign rq = link.read_queue_select;

	////////////////////////////////////////////////////////////////
	// Write port
	logic   wr_half_q;
	half_t  wr_lo_q;
	logic   full_w;

	assign full_w = ~active(wq, nq_q) | (level_q[wq] >= wpq_q);
	assign link.full_indicator = full_w;
	assign link.almost_full_indicator = ~active(wq, nq_q) |
	                                    (level_q[wq] + af_q[wq] >= wpq_q);

	// Full queue drops the write entirely
	assign push = link.wr_en & ~full_w & (wide_in_q | wr_half_q);
	assign push_word = wide_in_q ? link.wr_data :
	                   {link.wr_data[`MQ_HALF_BITS-1:0], wr_lo_q};

	// Narrow input pairs low half first
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wr_half_q <= 1'b0;
			wr_lo_q   <= '0;
		end else if (link.wr_en & ~full_w & ~wide_in_q) begin
			wr_half_q <= ~wr_half_q;
			wr_lo_q   <= link.wr_data[`MQ_HALF_BITS-1:0];
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			for (int i = 0; i < `MQ_NUM_QUEUES; i++) begin
				wptr_q[i] <= '0;
			end
		end else if (push) begin
			wptr_q[wq] <= (level_t'(wptr_q[wq]) + 19'h00001 >= wpq_q) ? '0 :
			              wptr_q[wq] + 18'h00001;
		end
	end

	////////////////////////////////////////////////////////////////
	// Read port
	logic  out_valid_q;
	logic  rd_half_q;
	qsel_t prev_rq_q;
	logic  sel_change;
	logic  consume;
	logic  need_load;
	word_t store_data;

	assign sel_change = (rq != prev_rq_q);
	assign consume    = link.rd_en & out_valid_q & (wide_out_q | rd_half_q);
	// Back-off-one keeps an unread word across a switch
	assign need_load  = ~out_valid_q | consume | (sel_change & ~backoff_q);
	assign pop        = need_load & active(rq, nq_q) & (level_q[rq] != '0);

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			prev_rq_q <= '0;
		end else begin
			prev_rq_q <= rq;
		end
	end

	// Without a load the last word stays on the bus
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			out_valid_q <= 1'b0;
		end else if (pop) begin
			out_valid_q <= 1'b1;
		end else if (need_load) begin
			out_valid_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rd_half_q <= 1'b0;
		end else if (pop) begin
			rd_half_q <= 1'b0;
		end else if (link.rd_en & out_valid_q & ~wide_out_q & ~rd_half_q) begin
			rd_half_q <= 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			for (int i = 0; i < `MQ_NUM_QUEUES; i++) begin
				rptr_q[i] <= '0;
			end
		end else if (pop) begin
			rptr_q[rq] <= (level_t'(rptr_q[rq]) + 19'h00001 >= wpq_q) ? '0 :
			              rptr_q[rq] + 18'h00001;
		end
	end

	assign link.rd_data = wide_out_q ? store_data :
	    {{(`MQ_WORD_BITS-`MQ_HALF_BITS){1'b0}},
	     rd_half_q ? store_data[`MQ_WORD_BITS-1:`MQ_HALF_BITS] :
	                 store_data[`MQ_HALF_BITS-1:0]};
	assign link.empty_indicator = ~out_valid_q;
	assign link.almost_empty_indicator = ~active(rq, nq_q) |
	                                     (level_q[rq] <= ae_q[rq]);

	////////////////////////////////////////////////////////////////
	// Fill levels, both ports at once
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			for (int i = 0; i < `MQ_NUM_QUEUES; i++) begin
				level_q[i] <= '0;
			end
		end else if (!(push && pop && wq == rq)) begin
			if (push) begin
				level_q[wq] <= level_q[wq] + 19'h00001;
			end
			if (pop) begin
				level_q[rq] <= level_q[rq] - 19'h00001;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Thresholds
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			for (int i = 0; i < `MQ_NUM_QUEUES; i++) begin
				af_q[i] <= `MQ_AF_DEFAULT;
				ae_q[i] <= `MQ_AE_DEFAULT;
			end
		end else if (thr_load_in) begin
			af_q[thr_queue_in] <= af_thr_in;
			ae_q[thr_queue_in] <= ae_thr_in;
		end
	end

	////////////////////////////////////////////////////////////////
	// Storage
	mq_store mq_store_inst (
		.clk_in      (clk_in),
		.wr_en_in    (push),
		.wr_addr_in  (word_addr(wq, wpq_q, wptr_q[wq])),
		.wr_data_in  (push_word),
		.rd_en_in    (pop),
		.rd_addr_in  (word_addr(rq, wpq_q, rptr_q[rq])),
		.rd_data_out (store_data)
	);
endmodule

//--- pkg/mq_map.svh
// Constants for the multi-queue flow-control core
`ifndef MQ_MAP_SVH
`define MQ_MAP_SVH
`define MQ_NUM_QUEUES   128
`define MQ_QSEL_BITS    7
`define MQ_WORD_BITS    40
`define MQ_HALF_BITS    20
`define MQ_BLOCK_WORDS  256
`define MQ_BLOCKS_HIGH  1024
`define MQ_BLOCKS_LOW   512
`define MQ_ADDR_BITS    18
`define MQ_LEVEL_BITS   19
`define MQ_AF_DEFAULT   19'h00008
`define MQ_AE_DEFAULT   19'h00008
`endif

//--- pkg/mq_pkg.sv
// Types shared by the multi-queue flow-control core
`include "mq_map.svh"
package mq_pkg;
	typedef logic [`MQ_QSEL_BITS-1:0]  qsel_t;
	typedef logic [`MQ_WORD_BITS-1:0]  word_t;
	typedef logic [`MQ_HALF_BITS-1:0]  half_t;
	typedef logic [`MQ_ADDR_BITS-1:0]  addr_t;
	typedef logic [`MQ_LEVEL_BITS-1:0] level_t;
endpackage

//--- pkg/mq_if.sv
// Write and read port link between queue core and user logic
`timescale 1ns/100ps
interface mq_if;
	import mq_pkg::*;
	logic   wr_en;
	word_t  wr_data;
	qsel_t  write_queue_select;
	logic   full_indicator;
	logic   almost_full_indicator;
	logic   rd_en;
	qsel_t  read_queue_select;
	word_t  rd_data;
	logic   empty_indicator;
	logic   almost_empty_indicator;
	modport device (
		input  wr_en, wr_data, write_queue_select, rd_en, read_queue_select,
		output full_indicator, almost_full_indicator, rd_data, empty_indicator,
		output almost_empty_indicator
	);
	modport host (
		output wr_en, wr_data, write_queue_select, rd_en, read_queue_select,
		input  full_indicator, almost_full_indicator, rd_data, empty_indicator,
		input  almost_empty_indicator
	);
endinterface

//--- src/mq_store.sv
// Shared word storage with one write and one registered read port
`timescale 1ns/100ps
`include "mq_map.svh"
module mq_store
	import mq_pkg::*;
(
	input  wire logic  clk_in,
	input  wire logic  wr_en_in,
	input  wire addr_t wr_addr_in,
	input  wire word_t wr_data_in,
	input  wire logic  rd_en_in,
	input  wire addr_t rd_addr_in,
	output word_t      rd_data_out
);
	word_t mem [0:(1<<`MQ_ADDR_BITS)-1];

	always_ff @(posedge clk_in) begin
		if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
	end

	// Output holds when no load
	always_ff @(posedge clk_in) begin
		if (rd_en_in) begin
			rd_data_out <= mem[rd_addr_in];
		end
	end
endmodule

//--- src/mq_user.sv
// Upstream writer and downstream reader end of the link
`timescale 1ns/100ps
`include "mq_map.svh"
module mq_user
	import mq_pkg::*;
(
	input  wire logic  clk_in,
	input  wire logic  rst_in,
	input  wire logic  push_valid_in,
	input  wire word_t push_data_in,
	input  wire qsel_t push_queue_in,
	output logic       push_ready_out,
	output logic       push_almost_full_out,
	input  wire qsel_t pop_queue_in,
	input  wire logic  pop_ready_in,
	output logic       pop_valid_out,
	output word_t      pop_data_out,
	output logic       pop_almost_empty_out,
	mq_if.host         link
);
	logic  hold_valid_q;
	word_t hold_data_q;
	qsel_t hold_queue_q;
	logic  send;

	// Write only while not full
	assign send = hold_valid_q & ~link.full_indicator;
	assign push_ready_out = ~hold_valid_q | send;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			hold_valid_q <= 1'b0;
			hold_data_q  <= '0;
			hold_queue_q <= '0;
		end else if (push_ready_out) begin
			hold_valid_q <= push_valid_in;
			if (push_valid_in) begin
				hold_data_q  <= push_data_in;
				hold_queue_q <= push_queue_in;
			end
		end
	end

	assign link.wr_en              = send;
	assign link.wr_data            = hold_data_q;
	assign link.write_queue_select = hold_queue_q;
	assign push_almost_full_out    = link.almost_full_indicator;

	// Read only a valid word
	assign link.rd_en             = pop_ready_in & ~link.empty_indicator;
	assign link.read_queue_select = pop_queue_in;
	assign pop_valid_out          = ~link.empty_indicator;
	assign pop_data_out           = link.rd_data;
	assign pop_almost_empty_out   = link.almost_empty_indicator;
endmodule

//--- test/mq_link_monitor.sv
// Property checker for the queue core link
`timescale 1ns/100ps
module mq_link_monitor
	import mq_pkg::*;
(
	input wire logic  clk_in,
	input wire logic  rst_in,
	input wire logic  wr_en,
	input wire qsel_t write_queue_select,
	input wire logic  full_indicator,
	input wire logic  almost_full_indicator,
	input wire logic  rd_en,
	input wire qsel_t read_queue_select,
	input wire word_t rd_data,
	input wire logic  empty_indicator,
	input wire logic  almost_empty_indicator
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	////////////////////////////////////////////////////////////////////////////////
	// Write into an empty, read-selected queue
	sequence s_wr_to_empty;
		wr_en && !full_indicator && empty_indicator && $stable(read_queue_select)
			&& write_queue_select == read_queue_select;
	endsequence
	// Full queue, valid output word, no read, no switch
	sequence s_idle_full;
		full_indicator && !rd_en && !empty_indicator && $stable(read_queue_select)
			&& $stable(write_queue_select);
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	a_no_full_write: assert property (!(wr_en && full_indicator))
		else $error("write while full");
	a_full_almost: assert property (full_indicator |-> almost_full_indicator)
		else $error("full without almost full");
	a_empty_reset: assert property ($fell(rst_in) |-> empty_indicator)
		else $error("data valid after reset");
	a_empty_hold: assert property ($rose(empty_indicator) |-> $stable(rd_data))
		else $error("output changed when queue ran dry");
	a_full_stays: assert property (s_idle_full |=> full_indicator)
		else $error("full dropped without a read");
	a_read_step: assert property (!empty_indicator && rd_en && $stable(read_queue_select)
		|=> empty_indicator || $changed(rd_data)) else $error("read gave no new word");
	a_write_shows: assert property (s_wr_to_empty |-> ##2 !empty_indicator)
		else $error("written word not presented");
	a_empty_almost: assert property ((empty_indicator && $stable(read_queue_select)) [*2]
		|-> almost_empty_indicator) else $error("empty queue not almost empty");
endmodule

//--- test/multi_queue_flow_core_bench.sv
// Self-checking bench driving both ends of the queue link
`timescale 1ns/100ps
module multi_queue_flow_core_bench;
	import mq_pkg::*;
	logic   clk_in;
	logic   rst_in;
	logic   thr_load;
	qsel_t  thr_queue;
	level_t af_thr;
	level_t ae_thr;
	logic   push_valid;
	word_t  push_data;
	qsel_t  push_queue;
	logic   push_ready;
	logic   push_af;
	qsel_t  pop_queue;
	logic   pop_ready;
	logic   pop_valid;
	word_t  pop_data;
	logic   pop_ae;
	logic   high_density;
	logic   wide_in;
	logic   wide_out;
	logic   back_off;
	int     err_count;
	int     num_checks;
	int     i;
	mq_if link ();
	mq_core mq_core_inst (.clk_in(clk_in), .rst_in(rst_in), .high_density_in(high_density),
		.num_queues_in(8'h80), .wide_in_in(wide_in), .wide_out_in(wide_out),
		.back_off_one_mode_in(back_off), .thr_load_in(thr_load), .thr_queue_in(thr_queue),
		.af_thr_in(af_thr), .ae_thr_in(ae_thr), .link(link));
	mq_user mq_user_inst (.clk_in(clk_in), .rst_in(rst_in), .push_valid_in(push_valid),
		.push_data_in(push_data), .push_queue_in(push_queue), .push_ready_out(push_ready),
		.push_almost_full_out(push_af), .pop_queue_in(pop_queue), .pop_ready_in(pop_ready),
		.pop_valid_out(pop_valid), .pop_data_out(pop_data), .pop_almost_empty_out(pop_ae),
		.link(link));
	mq_link_monitor mq_link_monitor_inst (.clk_in(clk_in), .rst_in(rst_in),
		.wr_en(link.wr_en), .write_queue_select(link.write_queue_select),
		.full_indicator(link.full_indicator), .almost_full_indicator(link.almost_full_indicator),
		.rd_en(link.rd_en), .read_queue_select(link.read_queue_select), .rd_data(link.rd_data),
		.empty_indicator(link.empty_indicator),
		.almost_empty_indicator(link.almost_empty_indicator));
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input word_t seen, input word_t exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic wait_hi(input logic on_pop);
		int n;
		for (n = 0; (on_pop ? pop_valid : push_ready) !== 1'b1; n++) begin
			if (n == 2000) begin
				err_count++;
				test_done;
			end
			@(posedge clk_in) #1;
		end
	endtask
	task automatic push(input qsel_t q, input word_t d);
		push_valid = 1'b1;
		push_queue = q;
		push_data = d;
		wait_hi(1'b0);
		@(posedge clk_in) #1;
	endtask
	task automatic pop(input word_t exp);
		pop_ready = 1'b1;
		wait_hi(1'b1);
		check("pop data", pop_data, exp);
		@(posedge clk_in) #1;
	endtask
	task automatic rest;
		push_valid = 1'b0;
		pop_ready = 1'b0;
		repeat (3) @(posedge clk_in) #1;
	endtask
	task automatic sel(input qsel_t q);
		pop_ready = 1'b0;
		pop_queue = q;
		repeat (3) @(posedge clk_in) #1;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	initial begin
		rst_in = 1'b1;
		{thr_load, thr_queue, af_thr, ae_thr} = '0;
		{push_valid, push_data, push_queue, pop_queue, pop_ready} = '0;
		{high_density, wide_in, wide_out, back_off} = 4'b0110;
		err_count = 0;
		num_checks = 0;
		repeat (10) @(posedge clk_in);
		#1 rst_in = 1'b0;
		@(posedge clk_in) #1;
		for (i = 0; i < 3; i++) begin
			push(7'h05, 40'h00000A0000 + word_t'(i));
			push(7'h09, 40'h00000B0000 + word_t'(i));
		end
		rest;
		sel(7'h09);
		for (i = 0; i < 3; i++) pop(40'h00000B0000 + word_t'(i));
		sel(7'h05);
		for (i = 0; i < 3; i++) pop(40'h00000A0000 + word_t'(i));
		sel(7'h14);
		check("valid on empty", word_t'(pop_valid), 40'h0000000000);
		check("held word", pop_data, 40'h00000A0002);
		$display("test steer done");
		fork
			begin
				for (int k = 0; k < 16; k++) push(7'h03, 40'h0000030000 + word_t'(k));
				push_valid = 1'b0;
			end
			begin
				sel(7'h03);
				for (int k = 0; k < 16; k++) pop(40'h0000030000 + word_t'(k));
			end
		join
		rest;
		$display("test overlap done");
		thr_queue = 7'h01;
		af_thr = 19'h003FC;
		ae_thr = 19'h00002;
		thr_load = 1'b1;
		@(posedge clk_in) #1 thr_load = 1'b0;
		for (i = 0; i < 3; i++) push(7'h01, 40'h0000010000 + word_t'(i));
		rest;
		check("almost full low", word_t'(push_af), 40'h0000000000);
		push(7'h01, 40'h0000010003);
		rest;
		check("almost full high", word_t'(push_af), 40'h0000000001);
		sel(7'h01);
		check("almost empty low", word_t'(pop_ae), 40'h0000000000);
		pop(40'h0000010000);
		rest;
		check("almost empty high", word_t'(pop_ae), 40'h0000000001);
		$display("test threshold done");
		for (i = 0; i < 1024; i++) push(7'h00, word_t'(i));
		rest;
		push_valid = 1'b1;
		push_data = 40'hFFFFFFFFFF;
		repeat (3) @(posedge clk_in) #1;
		check("ready when full", word_t'(push_ready), 40'h0000000000);
		rest;
		sel(7'h00);
		for (i = 0; i < 1024; i++) pop(word_t'(i));
		pop(40'hFFFFFFFFFF);
		rest;
		check("drained", word_t'(pop_valid), 40'h0000000000);
		$display("test full done");
		{push_valid, pop_ready} = 2'b00;
		{high_density, wide_in, wide_out, back_off} = 4'b1001;
		rst_in = 1'b1;
		repeat (4) @(posedge clk_in) #1;
		rst_in = 1'b0;
		@(posedge clk_in) #1;
		thr_queue = 7'h22;
		af_thr = 19'h007FE;
		thr_load = 1'b1;
		@(posedge clk_in) #1 thr_load = 1'b0;
		for (i = 0; i < 4; i++) push(7'h11, 40'h000000A000 + word_t'(i));
		push(7'h22, 40'h000000B000);
		push(7'h22, 40'h000000B001);
		rest;
		check("almost full wide pool", word_t'(push_af), 40'h0000000000);
		sel(7'h11);
		for (i = 0; i < 3; i++) pop(40'h000000A000 + word_t'(i));
		sel(7'h22);
		check("word kept on switch", pop_data, 40'h000000A003);
		pop(40'h000000A003);
		pop(40'h000000B000);
		pop(40'h000000B001);
		rest;
		check("narrow drained", word_t'(pop_valid), 40'h0000000000);
		$display("test narrow done");
		test_done;
	end
endmodule
